// file: rtl/scpb_pkg.sv
// Purpose: constants, register map and carrier types of the sensor clock, power and bias bank
// Assumes: one clock mclk, synchronous active-high reset, register port already decoded
// Notes: every register is one 16-bit word at its own address
package scpb_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int NUM_REGS = 10;
  localparam int NIB_W = 4;
  localparam int PGA_W = 7;

  localparam int IDX_CLKGEN = 0;
  localparam int IDX_LOGIC = 1;
  localparam int IDX_PIXPWR = 2;
  localparam int IDX_SLOPE = 3;
  localparam int IDX_FEPWR = 4;
  localparam int IDX_REFPWR = 5;
  localparam int IDX_CURREF = 6;
  localparam int IDX_FECUR = 7;
  localparam int IDX_SWCUR = 8;
  localparam int IDX_SOCUR = 9;

  localparam logic [ADDR_W-1:0] ADDR_CLOCK_GENERATOR_SETUP = 9'h020;
  localparam logic [ADDR_W-1:0] ADDR_LOGIC_ENABLE_CTRL = 9'h022;
  localparam logic [ADDR_W-1:0] ADDR_PIXEL_ARRAY_POWER_CTRL = 9'h028;
  localparam logic [ADDR_W-1:0] ADDR_SLOPE_RESET_LEVELS = 9'h029;
  localparam logic [ADDR_W-1:0] ADDR_FRONTEND_POWER_CTRL = 9'h030;
  localparam logic [ADDR_W-1:0] ADDR_REFERENCE_POWER_CTRL = 9'h040;
  localparam logic [ADDR_W-1:0] ADDR_CURRENT_REFERENCE_SETUP = 9'h041;
  localparam logic [ADDR_W-1:0] ADDR_FRONTEND_CURRENT_SETUP = 9'h042;
  localparam logic [ADDR_W-1:0] ADDR_COLUMN_SWITCH_CURRENT_SETUP = 9'h043;
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_OUTPUT_CURRENT_SETUP = 9'h044;

  localparam logic [DATA_W-1:0] RST_CLOCK_GENERATOR_SETUP = 16'h0004;
  localparam logic [DATA_W-1:0] RST_LOGIC_ENABLE_CTRL = 16'h0000;
  localparam logic [DATA_W-1:0] RST_PIXEL_ARRAY_POWER_CTRL = 16'h0000;
  localparam logic [DATA_W-1:0] RST_SLOPE_RESET_LEVELS = 16'h0b5a;
  localparam logic [DATA_W-1:0] RST_FRONTEND_POWER_CTRL = 16'h0000;
  localparam logic [DATA_W-1:0] RST_REFERENCE_POWER_CTRL = 16'h0000;
  localparam logic [DATA_W-1:0] RST_CURRENT_REFERENCE_SETUP = 16'h888b;
  localparam logic [DATA_W-1:0] RST_FRONTEND_CURRENT_SETUP = 16'h53c8;
  localparam logic [DATA_W-1:0] RST_COLUMN_SWITCH_CURRENT_SETUP = 16'h8888;
  localparam logic [DATA_W-1:0] RST_SERIAL_OUTPUT_CURRENT_SETUP = 16'h0088;

  localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REGS] = '{
    ADDR_CLOCK_GENERATOR_SETUP, ADDR_LOGIC_ENABLE_CTRL, ADDR_PIXEL_ARRAY_POWER_CTRL,
    ADDR_SLOPE_RESET_LEVELS, ADDR_FRONTEND_POWER_CTRL, ADDR_REFERENCE_POWER_CTRL,
    ADDR_CURRENT_REFERENCE_SETUP, ADDR_FRONTEND_CURRENT_SETUP,
    ADDR_COLUMN_SWITCH_CURRENT_SETUP, ADDR_SERIAL_OUTPUT_CURRENT_SETUP};

  localparam logic [DATA_W-1:0] REG_RST [NUM_REGS] = '{
    RST_CLOCK_GENERATOR_SETUP, RST_LOGIC_ENABLE_CTRL, RST_PIXEL_ARRAY_POWER_CTRL,
    RST_SLOPE_RESET_LEVELS, RST_FRONTEND_POWER_CTRL, RST_REFERENCE_POWER_CTRL,
    RST_CURRENT_REFERENCE_SETUP, RST_FRONTEND_CURRENT_SETUP,
    RST_COLUMN_SWITCH_CURRENT_SETUP, RST_SERIAL_OUTPUT_CURRENT_SETUP};

  localparam int CG_ANALOG_BIT = 0;
  localparam int CG_LOGIC_BIT = 1;
  localparam int CG_SRC_BIT = 2;
  localparam int CG_ADC8_BIT = 3;
  localparam int LE_EN_BIT = 0;
  localparam int PA_CORE_BIT = 0;
  localparam int PA_MUX_BIT = 1;
  localparam int PA_COLBIAS_BIT = 2;
  localparam int SL_DOUBLE_LSB = 0;
  localparam int SL_TRIPLE_LSB = 4;
  localparam int FE_PWR_BIT = 0;
  localparam int RP_BG_BIT = 0;
  localparam int CR_EXTRES_BIT = 0;
  localparam int CR_PRECH_LSB = 4;
  localparam int CR_COLB_LSB = 8;
  localparam int CR_PUMP_LSB = 12;
  localparam int FC_AFE_LSB = 0;
  localparam int FC_ADCREF_LSB = 4;
  localparam int FC_PGA_LSB = 8;
  localparam int SW_ONE_LSB = 0;
  localparam int SW_TWO_LSB = 4;
  localparam int SO_BIAS_LSB = 0;
  localparam int SO_REF_LSB = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } scpb_req_t;

  typedef struct packed {
    logic analogClkEn;
    logic logicClkEn;
    logic clkSrcSynth;
    logic adc8Bit;
    logic logicEnable;
    logic coreUp;
    logic colMuxUp;
    logic colBiasEn;
    logic [NIB_W-1:0] double_slope_level;
    logic [NIB_W-1:0] triple_slope_level;
    logic frontendUp;
    logic bandgapUp;
    logic extResistor;
    logic [NIB_W-1:0] colPrechargeTrim;
    logic [NIB_W-1:0] colBiasTrim;
    logic [NIB_W-1:0] pump_current_trim;
    logic [NIB_W-1:0] afeCurrentTrim;
    logic [NIB_W-1:0] adcRefTrim;
    logic [PGA_W-1:0] pgaRefTrim;
    logic [NIB_W-1:0] switch_stage_one_current;
    logic [NIB_W-1:0] switch_stage_two_current;
    logic [NIB_W-1:0] serialBiasTrim;
    logic [NIB_W-1:0] serialRefTrim;
  } scpb_cfg_t;

  function automatic logic [NIB_W-1:0] scpb_nib(input logic [DATA_W-1:0] w, input int lsb);
    logic [DATA_W-1:0] sh;
    sh = w >> lsb;
    return sh[NIB_W-1:0];
  endfunction

endpackage

// file: rtl/scpb_reg16.sv
// Purpose: one 16-bit configuration word with its own reset value
// Assumes: write strobe already qualified by clock enable and address hit
// Notes: reset acts on the edge whatever the clock enable
module scpb_reg16 #(
  parameter logic [scpb_pkg::DATA_W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wrStb,
  input wire logic [scpb_pkg::DATA_W-1:0] wrData,
  output logic [scpb_pkg::DATA_W-1:0] q
);

  logic [scpb_pkg::DATA_W-1:0] word_r;
  logic [scpb_pkg::DATA_W-1:0] word_nxt;

  assign word_nxt = wrStb ? wrData : word_r;
  assign q = word_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      word_r <= RST_VAL;
    end else begin
      word_r <= word_nxt;
    end
  end

endmodule

// file: rtl/scpb_addr_dec.sv
// Purpose: one-hot address decode of the register map
// Assumes: addresses in the map are distinct
// Notes: hit low marks an unmapped address
module scpb_addr_dec (
  input wire logic [scpb_pkg::ADDR_W-1:0] addr,
  output logic [scpb_pkg::NUM_REGS-1:0] hitVec,
  output logic hit
);

  genvar i;
  generate
    for (i = 0; i < scpb_pkg::NUM_REGS; i++) begin : g_dec
      assign hitVec[i] = (addr == scpb_pkg::REG_ADDR[i]);
    end
  endgenerate

  assign hit = |hitVec;

endmodule

// file: rtl/scpb_regs.sv
// Purpose: clock, power and bias configuration bank with a word-wide register port
// Assumes: serial control port already turned into decoded word requests on mclk
// Notes: read data appears one cycle after the request; unmapped reads return zero
module scpb_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire scpb_pkg::scpb_req_t req,
  output logic [scpb_pkg::DATA_W-1:0] rdData,
  output logic rdValid,
  output logic accessErr,
  output scpb_pkg::scpb_cfg_t cfg
);

  logic [scpb_pkg::DATA_W-1:0] regQ [scpb_pkg::NUM_REGS];
  logic [scpb_pkg::NUM_REGS-1:0] hitVec;
  logic hit;
  logic wrTake;
  logic rdTake;
  logic [scpb_pkg::DATA_W-1:0] rdMux;
  logic [scpb_pkg::DATA_W-1:0] rdData_r;
  logic [scpb_pkg::DATA_W-1:0] rdData_nxt;
  logic rdValid_r;
  logic rdValid_nxt;
  logic accessErr_r;
  logic accessErr_nxt;

  // write wins the port if both strobes come together
  assign wrTake = ce & req.wr;
  assign rdTake = ce & req.rd & ~req.wr;

  scpb_addr_dec u_dec (
    .addr(req.addr),
    .hitVec(hitVec),
    .hit(hit)
  );

  genvar i;
  generate
    for (i = 0; i < scpb_pkg::NUM_REGS; i++) begin : g_reg
      scpb_reg16 #(
        .RST_VAL(scpb_pkg::REG_RST[i])
      ) u_reg (
        .mclk(mclk),
        .rst(rst),
        .wrStb(wrTake & hitVec[i]),
        .wrData(req.wdata),
        .q(regQ[i])
      );
    end
  endgenerate

  // one-hot select; no hit leaves zero
  always_comb begin
    rdMux = '0;
    for (int k = 0; k < scpb_pkg::NUM_REGS; k++) begin
      if (hitVec[k]) begin
        rdMux = rdMux | regQ[k];
      end
    end
  end

  assign rdData_nxt = rdTake ? rdMux : rdData_r;
  assign rdValid_nxt = ce ? rdTake : rdValid_r;
  assign accessErr_nxt = ce ? ((wrTake | rdTake) & ~hit) : accessErr_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdData_r <= '0;
      rdValid_r <= 1'b0;
      accessErr_r <= 1'b0;
    end else begin
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
      accessErr_r <= accessErr_nxt;
    end
  end

  assign rdData = rdData_r;
  // pulses stay one active cycle even when ce stalls
  assign rdValid = rdValid_r & ce;
  assign accessErr = accessErr_r & ce;

  // clock generator controls and logic enable
  assign cfg.analogClkEn = regQ[scpb_pkg::IDX_CLKGEN][scpb_pkg::CG_ANALOG_BIT];
  assign cfg.logicClkEn = regQ[scpb_pkg::IDX_CLKGEN][scpb_pkg::CG_LOGIC_BIT];
  assign cfg.clkSrcSynth = regQ[scpb_pkg::IDX_CLKGEN][scpb_pkg::CG_SRC_BIT];
  assign cfg.adc8Bit = regQ[scpb_pkg::IDX_CLKGEN][scpb_pkg::CG_ADC8_BIT];
  assign cfg.logicEnable = regQ[scpb_pkg::IDX_LOGIC][scpb_pkg::LE_EN_BIT];

  // image core
  assign cfg.coreUp = regQ[scpb_pkg::IDX_PIXPWR][scpb_pkg::PA_CORE_BIT];
  assign cfg.colMuxUp = regQ[scpb_pkg::IDX_PIXPWR][scpb_pkg::PA_MUX_BIT];
  assign cfg.colBiasEn = regQ[scpb_pkg::IDX_PIXPWR][scpb_pkg::PA_COLBIAS_BIT];
  assign cfg.double_slope_level =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_SLOPE], scpb_pkg::SL_DOUBLE_LSB);
  assign cfg.triple_slope_level =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_SLOPE], scpb_pkg::SL_TRIPLE_LSB);

  // power downs
  assign cfg.frontendUp = regQ[scpb_pkg::IDX_FEPWR][scpb_pkg::FE_PWR_BIT];
  assign cfg.bandgapUp = regQ[scpb_pkg::IDX_REFPWR][scpb_pkg::RP_BG_BIT];

  // bias trims
  assign cfg.extResistor = regQ[scpb_pkg::IDX_CURREF][scpb_pkg::CR_EXTRES_BIT];
  assign cfg.colPrechargeTrim =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_CURREF], scpb_pkg::CR_PRECH_LSB);
  assign cfg.colBiasTrim =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_CURREF], scpb_pkg::CR_COLB_LSB);
  assign cfg.pump_current_trim =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_CURREF], scpb_pkg::CR_PUMP_LSB);
  assign cfg.afeCurrentTrim =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_FECUR], scpb_pkg::FC_AFE_LSB);
  assign cfg.adcRefTrim =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_FECUR], scpb_pkg::FC_ADCREF_LSB);
  assign cfg.pgaRefTrim =
    regQ[scpb_pkg::IDX_FECUR][scpb_pkg::FC_PGA_LSB +: scpb_pkg::PGA_W];
  assign cfg.switch_stage_one_current =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_SWCUR], scpb_pkg::SW_ONE_LSB);
  assign cfg.switch_stage_two_current =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_SWCUR], scpb_pkg::SW_TWO_LSB);
  assign cfg.serialBiasTrim =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_SOCUR], scpb_pkg::SO_BIAS_LSB);
  assign cfg.serialRefTrim =
    scpb_pkg::scpb_nib(regQ[scpb_pkg::IDX_SOCUR], scpb_pkg::SO_REF_LSB);

endmodule

// file: tb/scpb_regs_sva.sv
// Purpose: port checks of the clock, power and bias bank
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to scpb_regs after the module
module scpb_regs_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire scpb_pkg::scpb_req_t req,
  input wire logic [scpb_pkg::DATA_W-1:0] rdData,
  input wire logic rdValid,
  input wire logic accessErr,
  input wire scpb_pkg::scpb_cfg_t cfg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mapped;
  assign mapped = req.addr inside {9'h020, 9'h022, 9'h028, 9'h029, 9'h030, 9'h040, 9'h041,
    9'h042, 9'h043, 9'h044};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_wr(a);
    ce && req.wr && req.addr == a;
  endsequence
  sequence s_rd;
    ce && req.rd && !req.wr;
  endsequence
  a_clk_gen_bits: assert property (s_wr(9'h020) |=>
    {cfg.adc8Bit, cfg.clkSrcSynth, cfg.logicClkEn, cfg.analogClkEn} == $past(req.wdata[3:0]))
    else $error("clock setup bits wrong");
  a_logic_en_bit: assert property (s_wr(9'h022) |=> cfg.logicEnable == $past(req.wdata[0]))
    else $error("logic enable wrong");
  a_pix_power_bits: assert property (s_wr(9'h028) |=>
    {cfg.colMuxUp, cfg.coreUp} == $past(req.wdata[1:0])) else $error("pixel power wrong");
  a_slope_levels: assert property (s_wr(9'h029) |=>
    {cfg.triple_slope_level, cfg.double_slope_level} == $past(req.wdata[7:0]))
    else $error("slope levels wrong");
  a_fe_power_bit: assert property (s_wr(9'h030) |=> cfg.frontendUp == $past(req.wdata[0]))
    else $error("front-end power wrong");
  a_bandgap_bit: assert property (s_wr(9'h040) |=> cfg.bandgapUp == $past(req.wdata[0]))
    else $error("bandgap power wrong");
  a_cur_ref_fields: assert property (s_wr(9'h041) |=>
    {cfg.pump_current_trim, cfg.colBiasTrim, cfg.colPrechargeTrim, cfg.extResistor}
    == {$past(req.wdata[15:4]), $past(req.wdata[0])}) else $error("current setup wrong");
  a_switch_trims: assert property (s_wr(9'h043) |=>
    {cfg.switch_stage_two_current, cfg.switch_stage_one_current} == $past(req.wdata[7:0]))
    else $error("switch trims wrong");
  a_reset_loads: assert property (disable iff (1'b0) rst |=>
    cfg.clkSrcSynth && cfg.extResistor && !cfg.coreUp && cfg.double_slope_level == 4'ha
    && cfg.triple_slope_level == 4'h5 && cfg.pump_current_trim == 4'h8)
    else $error("reset defaults wrong");
  a_cfg_holds: assert property (!(ce && req.wr) |=> $stable(cfg))
    else $error("config changed without write");
  a_read_strobe: assert property (s_rd ##1 ce |-> rdValid)
    else $error("read strobe missing");
  a_unmapped_err: assert property (ce && (req.wr || req.rd) && !mapped |=> !ce || accessErr)
    else $error("unmapped access not flagged");
  a_unmapped_zero: assert property (s_rd and !mapped |=> rdData == 16'h0000)
    else $error("unmapped read not zero");
endmodule

bind scpb_regs scpb_regs_sva u_scpb_regs_sva (.mclk(mclk), .rst(rst), .ce(ce), .req(req),
  .rdData(rdData), .rdValid(rdValid), .accessErr(accessErr), .cfg(cfg));

// file: tb/scpb_regs_tb_top.sv
// Purpose: random and corner write/read traffic on the clock, power and bias bank
// Assumes: inputs change 5 ns after the rising edge
// Notes: reserved fields written only with defaults
module scpb_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, ce, rdValid, accessErr;
  scpb_pkg::scpb_req_t req;
  scpb_pkg::scpb_cfg_t cfg;
  logic [scpb_pkg::DATA_W-1:0] rdData, d;
  logic [15:0] m [10];
  int failures, n_checks, seed;
  localparam logic [15:0] MSK [10] = '{16'h000f, 16'h0001, 16'h0007, 16'h00ff, 16'h0001,
    16'h0001, 16'hfff1, 16'h7fff, 16'h00ff, 16'h00ff};
  scpb_regs u_scpb_regs (.mclk(mclk), .rst(rst), .ce(ce), .req(req), .rdData(rdData),
    .rdValid(rdValid), .accessErr(accessErr), .cfg(cfg));
  always #25 mclk = ~mclk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [8:0] a, input logic [15:0] dt);
    req = '{wr: w, rd: !w, addr: a, wdata: dt};
    @(posedge mclk);
    #5;
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] e, input logic err);
    acc(1'b0, a, 16'h0000);
    chk({rdValid, accessErr, rdData}, {1'b1, err, e});
  endtask
  function automatic logic [37:0] cfg_exp();
    return {m[0][3:0], m[1][0], m[2][1:0], m[3][7:0], m[4][0], m[5][0], m[6][15:4], m[6][0],
      m[8][7:0]};
  endfunction
  task automatic check_all();
    logic [37:0] e;
    for (int i = 0; i < 10; i++) rd(scpb_pkg::REG_ADDR[i], m[i], 1'b0);
    e = cfg_exp();
    chk({cfg.adc8Bit, cfg.clkSrcSynth, cfg.logicClkEn, cfg.analogClkEn},
      e[37:34]);
    chk(cfg.logicEnable, e[33]);
    chk({cfg.colMuxUp, cfg.coreUp}, e[32:31]);
    chk({cfg.triple_slope_level, cfg.double_slope_level}, e[30:23]);
    chk(cfg.frontendUp, e[22]);
    chk(cfg.bandgapUp, e[21]);
    chk({cfg.pump_current_trim, cfg.colBiasTrim, cfg.colPrechargeTrim, cfg.extResistor},
      e[20:8]);
    chk({cfg.switch_stage_two_current, cfg.switch_stage_one_current}, e[7:0]);
    chk({cfg.colBiasEn, cfg.pgaRefTrim, cfg.adcRefTrim, cfg.afeCurrentTrim, cfg.serialRefTrim,
      cfg.serialBiasTrim}, {m[2][2], m[7][14:0], m[9][7:0]});
  endtask
  task automatic do_reset();
    req = '0;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    #5;
    rst = 1'b0;
    @(posedge mclk);
    #5;
    chk({rdValid, accessErr, rdData}, '0);
    for (int i = 0; i < 10; i++) m[i] = scpb_pkg::REG_RST[i];
  endtask
  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    seed = 32'h2efad088;
    failures = 0;
    n_checks = 0;
    #5;
    do_reset();
    check_all();
    for (int r = 0; r < 30; r++) begin
      for (int i = 0; i < 10; i++) begin
        d = (16'($random(seed)) & MSK[i]) | (scpb_pkg::REG_RST[i] & ~MSK[i]);
        if (r < 2) d = r ? scpb_pkg::REG_RST[i] & ~MSK[i] : MSK[i] | scpb_pkg::REG_RST[i];
        ce = (r % 7 != 3);
        acc(1'b1, scpb_pkg::REG_ADDR[i], d);
        if (ce) m[i] = d;
        ce = 1'b1;
        rd(scpb_pkg::REG_ADDR[i], m[i], 1'b0);
      end
      check_all();
    end
    acc(1'b1, 9'h021, 16'hffff);
    chk(accessErr, 1'b1);
    rd(9'h021, 16'h0000, 1'b1);
    rd(9'h1ff, 16'h0000, 1'b1);
    // write and read together: write wins, no read answer
    d = {15'h0000, ~m[1][0]};
    req = '{wr: 1'b1, rd: 1'b1, addr: scpb_pkg::ADDR_LOGIC_ENABLE_CTRL, wdata: d};
    @(posedge mclk);
    #5;
    chk({rdValid, accessErr, cfg.logicEnable}, {2'b00, d[0]});
    m[1] = d;
    check_all();
    do_reset();
    check_all();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    give_verdict();
  end
endmodule
